// [core/acc_pkg.sv]
// package: register map, field positions and types of the conversion control block
package acc_pkg;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  // printed offset 0xE1 is not word aligned, so 0xE1 and 0xE8 are both taken as indices
  localparam logic [7:0] ACC_IDX_CTRL_ONE = 8'hE1;
  localparam logic [7:0] ACC_IDX_CTRL_ZERO = 8'hE8;
  localparam logic [11:0] ACC_ADDR_CTRL_ONE = {2'h0, ACC_IDX_CTRL_ONE, 2'h0};
  localparam logic [11:0] ACC_ADDR_CTRL_ZERO = {2'h0, ACC_IDX_CTRL_ZERO, 2'h0};
  localparam logic [11:0] ACC_ADDR_BITOP = 12'h400;
  localparam logic [11:0] ACC_ADDR_STATUS = 12'h404;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int ACC_C0_DONE = 7;
  localparam int ACC_C0_BUSY = 6;
  localparam int ACC_C1_SWAP = 6;
  localparam int ACC_C1_EXT_EN = 1;
  localparam int ACC_C1_CONV_EN = 0;
  localparam logic [7:0] ACC_C1_WMASK = 8'h4F;
  localparam logic [7:0] ACC_CTRL_ZERO_RST = 8'h00;
  localparam logic [7:0] ACC_CTRL_ONE_RST = 8'h00;
  localparam logic [3:0] ACC_CH_BANDGAP = 4'h8;
  localparam logic [7:0] ACC_SAR_LAT_DEF = 8'h0E;

  // ************************************************************
  // encodings and types
  // ************************************************************
  localparam logic [1:0] ACC_SRC_PWM_CHANNEL_ZERO = 2'h0;
  localparam logic [1:0] ACC_SRC_PWM_CHANNEL_TWO = 2'h1;
  localparam logic [1:0] ACC_SRC_PWM_CHANNEL_FOUR = 2'h2;
  localparam logic [1:0] ACC_SRC_PIN = 2'h3;
  localparam logic [1:0] ACC_TRG_FALL = 2'h0;
  localparam logic [1:0] ACC_TRG_RISE = 2'h1;
  localparam logic [1:0] ACC_TRG_CENTRE = 2'h2;
  localparam logic [1:0] ACC_TRG_END = 2'h3;

  typedef struct packed {
    logic conv_done_flag;
    logic conv_start_busy;
    logic [1:0] ext_trig_source_sel;
    logic [3:0] input_channel_sel;
  } acc_ctrl_zero_t;

  typedef struct packed {
    logic rsv7;
    logic trig_pin_swap;
    logic [1:0] rsv5;
    logic [1:0] ext_trig_condition;
    logic ext_trig_enable;
    logic converter_enable;
  } acc_ctrl_one_t;

  typedef struct packed {
    logic [2:0] pwm_level;
    logic [2:0] pwm_centre;
    logic [2:0] pwm_end;
  } acc_pwm_t;

  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_CONV = 3'b010,
    ACC_WAIT = 3'b100
  } acc_state_t;

endpackage

// [core/acc_conv_ctrl.sv]
// design: conversion start, busy, done and trigger control with apb register slave
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
// ************************************************************
// Summary of operation
// (R01) done flag set when conversion finishes
// (R02) no new conversion while done flag set
// (R03) software clears the done flag
// (R04) writing start bit one launches conversion
// (R05) busy reads one during conversion, then clears
// (R06) source field picks pwm 0/2/4 or pin
// (R07) channel code routes inputs or band-gap
// (R08) disabled converter disconnects all inputs
// (R09) swap bit picks port0 bit4 or port1 bit3
// (R10) swap takes effect immediately, no sync
// (R11) condition field: fall, rise, centre, end
// (R12) centre/end only with centre-aligned pwm
// (R13) hardware trigger only when external enabled
// (R14) triggers while busy are dropped, never queued
// (R15) enable bit powers converter on or off
// (R16) control zero supports single bit set/clear
// (R17) hardware start also sets busy bit
// (R18) completion raises interrupt request when enabled
// (R19) software start while busy silently ignored
// (R20) wait for core done with configurable latency
// ************************************************************
module acc_conv_ctrl import acc_pkg::*; #(
  parameter logic [7:0] SAR_LATENCY = ACC_SAR_LAT_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // trigger sources
  input wire acc_pwm_t pwm_in,
  input wire logic port0_bit4,
  input wire logic port1_bit3,
  input wire logic conv_irq_enable,
  // analog core
  input wire logic sar_done,
  output logic sar_start,
  output logic sar_power_on,
  output logic [8:0] sar_input_connect,
  output logic conv_irq
);

  // ************************************************************
  // state
  // ************************************************************
  acc_ctrl_zero_t c0_r;
  acc_ctrl_zero_t c0_nxt;
  acc_ctrl_one_t c1_r;
  acc_ctrl_one_t c1_nxt;
  acc_state_t st_r;
  acc_state_t st_nxt;
  logic [7:0] lat_r;
  logic [7:0] lat_nxt;
  logic trg_prev_r;
  logic trg_prev_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt;
  logic pslverr_nxt;
  logic start_nxt;
  logic irq_nxt;
  logic power_nxt;
  logic [8:0] connect_nxt;
  logic trg_level;
  logic trg_event;
  logic sw_start;
  logic hw_start;
  logic go;
  logic access;
  logic wr;
  logic hit;
  logic wr_zero;
  logic wr_one;
  logic wr_bit;
  logic rd_setup;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  // ************************************************************
  // helpers
  // ************************************************************
  // one-hot routing; reserved codes and a powered-down converter route nothing
  function automatic logic [8:0] acc_route(input logic en, input logic [3:0] ch);
    logic [8:0] r;
    r = 9'h000;
    if (en && ch <= ACC_CH_BANDGAP) begin
      r[ch] = 1'b1;
    end
    return r;
  endfunction

  // pwm channel picked by the source field; the pin source picks none
  function automatic logic [2:0] acc_src_mask(input logic [1:0] src);
    logic [2:0] m;
    m = 3'h0;
    unique case (src)
      ACC_SRC_PWM_CHANNEL_ZERO: m = 3'h1;
      ACC_SRC_PWM_CHANNEL_TWO: m = 3'h2;
      ACC_SRC_PWM_CHANNEL_FOUR: m = 3'h4;
      ACC_SRC_PIN: m = 3'h0;
    endcase
    return m;
  endfunction

  // true for an address that names a register of this block
  function automatic logic acc_known(input logic [11:0] a);
    return a == ACC_ADDR_CTRL_ZERO || a == ACC_ADDR_CTRL_ONE || a == ACC_ADDR_BITOP || a == ACC_ADDR_STATUS;
  endfunction

  // ************************************************************
  // trigger source
  // ************************************************************
  always_comb begin
    unique case (c0_r.ext_trig_source_sel) // R06
      ACC_SRC_PWM_CHANNEL_ZERO: begin
        trg_level = pwm_in.pwm_level[0];
      end
      ACC_SRC_PWM_CHANNEL_TWO: begin
        trg_level = pwm_in.pwm_level[1];
      end
      ACC_SRC_PWM_CHANNEL_FOUR: begin
        trg_level = pwm_in.pwm_level[2];
      end
      // swap acts straight on the mux, so a swap can itself look like an edge
      ACC_SRC_PIN: begin
        trg_level = c1_r.trig_pin_swap ? port1_bit3 : port0_bit4; // R09 R10
      end
    endcase
    trg_prev_nxt = trg_level;
  end

  // ************************************************************
  // trigger condition
  // ************************************************************
  always_comb begin
    trg_event = 1'b0;
    // centre/end events only pulse when the pwm runs centre-aligned
    unique case (c1_r.ext_trig_condition) // R11
      ACC_TRG_FALL: begin
        trg_event = trg_prev_r & ~trg_level;
      end
      ACC_TRG_RISE: begin
        trg_event = ~trg_prev_r & trg_level;
      end
      ACC_TRG_CENTRE: begin
        trg_event = |(pwm_in.pwm_centre & acc_src_mask(c0_r.ext_trig_source_sel));
      end
      ACC_TRG_END: begin
        trg_event = |(pwm_in.pwm_end & acc_src_mask(c0_r.ext_trig_source_sel));
      end
    endcase
    hw_start = c1_r.ext_trig_enable & trg_event; // R13
  end

  // ************************************************************
  // apb decode
  // ************************************************************
  always_comb begin
    access = psel & penable;
    wr = access & pwrite & pstrb[0];
    wbyte = pwdata[7:0];
    hit = acc_known(paddr);
    rd_setup = psel & ~penable & ~pwrite;
    wr_zero = wr && paddr == ACC_ADDR_CTRL_ZERO;
    wr_one = wr && paddr == ACC_ADDR_CTRL_ONE;
    wr_bit = wr && paddr == ACC_ADDR_BITOP;
  end

  // ************************************************************
  // control registers and conversion sequencing
  // ************************************************************
  always_comb begin
    c0_nxt = c0_r;
    c1_nxt = c1_r;
    st_nxt = st_r;
    lat_nxt = lat_r;
    start_nxt = 1'b0;
    irq_nxt = 1'b0;
    sw_start = 1'b0;
    if (wr_zero) begin
      c0_nxt.conv_done_flag = wbyte[ACC_C0_DONE]; // R03
      c0_nxt.ext_trig_source_sel = wbyte[5:4];
      c0_nxt.input_channel_sel = wbyte[3:0];
      // the busy bit is never written: a one only asks for a start
      sw_start = wbyte[ACC_C0_BUSY]; // R04
    end
    // bit operation: pwdata[2:0] bit number, pwdata[3] value written
    if (wr_bit) begin // R16
      if (pwdata[2:0] == 3'(ACC_C0_BUSY)) begin
        sw_start = pwdata[3];
      end else begin
        c0_nxt[pwdata[2:0]] = pwdata[3];
      end
    end
    if (wr_one) begin
      c1_nxt = wbyte & ACC_C1_WMASK; // R15
    end
    // busy and done both block: late triggers are simply lost
    go = (sw_start | hw_start) & ~c0_r.conv_start_busy & ~c0_r.conv_done_flag; // R02 R14 R19
    unique case (st_r)
      ACC_IDLE: begin
        if (go) begin
          c0_nxt.conv_start_busy = 1'b1; // R05 R17
          start_nxt = 1'b1;
          lat_nxt = SAR_LATENCY;
          st_nxt = ACC_CONV;
        end
      end
      ACC_CONV: begin
        if (lat_r != 8'h00) begin
          lat_nxt = lat_r - 8'h01;
        end else begin
          st_nxt = ACC_WAIT;
        end
      end
      // completion is applied after any software write, so setting the flag wins
      ACC_WAIT: begin
        if (sar_done) begin // R20
          c0_nxt.conv_start_busy = 1'b0; // R05
          c0_nxt.conv_done_flag = 1'b1; // R01
          irq_nxt = conv_irq_enable; // R18
          st_nxt = ACC_IDLE;
        end
      end
    endcase
  end

  // ************************************************************
  // apb response
  // ************************************************************
  // read data is taken in the setup cycle and stands until the next read
  always_comb begin
    rbyte = 8'h00;
    if (paddr == ACC_ADDR_CTRL_ZERO) begin
      rbyte = c0_r;
    end else if (paddr == ACC_ADDR_CTRL_ONE) begin
      rbyte = c1_r;
    end else if (paddr == ACC_ADDR_STATUS) begin
      rbyte = {5'h00, st_r};
    end
    prdata_nxt = rd_setup ? {24'h000000, rbyte} : prdata;
    // zero wait states: ready in every access cycle
    pready_nxt = psel & ~penable;
    pslverr_nxt = psel & ~penable & ~hit;
  end

  // ************************************************************
  // analog core controls
  // ************************************************************
  always_comb begin
    power_nxt = c1_nxt.converter_enable; // R15
    connect_nxt = acc_route(c1_nxt.converter_enable, c0_nxt.input_channel_sel); // R07 R08
  end

  // ************************************************************
  // control register flops
  // ************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      c0_r <= ACC_CTRL_ZERO_RST;
      c1_r <= ACC_CTRL_ONE_RST;
    end else begin
      c0_r <= c0_nxt;
      c1_r <= c1_nxt;
    end
  end

  // ************************************************************
  // sequencer flops
  // ************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= ACC_IDLE;
      lat_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      lat_r <= lat_nxt;
    end
  end

  // ************************************************************
  // trigger history flop
  // ************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trg_prev_r <= 1'b0;
    end else begin
      trg_prev_r <= trg_prev_nxt;
    end
  end

  // ************************************************************
  // apb response flops
  // ************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // ************************************************************
  // core handshake flops
  // ************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sar_start <= 1'b0;
      conv_irq <= 1'b0;
    end else begin
      sar_start <= start_nxt;
      conv_irq <= irq_nxt;
    end
  end

  // ************************************************************
  // analog routing flops
  // ************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sar_power_on <= 1'b0;
      sar_input_connect <= 9'h000;
    end else begin
      sar_power_on <= power_nxt;
      sar_input_connect <= connect_nxt;
    end
  end

endmodule

// [bench/acc_chk.sv]
// checker: port level assertions for the conversion control block
`timescale 1ns/1ps
module acc_chk import acc_pkg::*; #(
  parameter logic [7:0] SAR_LATENCY = ACC_SAR_LAT_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // core side
  input wire logic conv_irq_enable,
  input wire logic sar_done,
  input wire logic sar_start,
  input wire logic sar_power_on,
  input wire logic [8:0] sar_input_connect,
  input wire logic conv_irq
);
  // ****
  // cycles since last start, saturating so a long idle never wraps
  // ****
  int gap_r;
  int gap_nxt;
  always_comb gap_nxt = sar_start ? 0 : (gap_r < 255 ? gap_r + 1 : gap_r);
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      gap_r <= 255;
    else
      gap_r <= gap_nxt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_READY: assert property (psel && penable |-> pready) else $error("no ready");
  AST_ERR: assert property (pslverr |-> pready && psel && penable) else $error("stray error");
  AST_OFF: assert property (!sar_power_on |-> sar_input_connect == 9'h0) else $error("input on");
  AST_ONEHOT: assert property ($onehot0(sar_input_connect)) else $error("two inputs");
  AST_START_ONE: assert property (sar_start |=> !sar_start) else $error("long start");
  AST_GAP: assert property (sar_start |-> gap_r > SAR_LATENCY) else $error("early start");
  AST_IRQ: assert property (conv_irq |-> $past(sar_done) && $past(conv_irq_enable)) else $error("irq");
  AST_IRQ_ONE: assert property (conv_irq |=> !conv_irq) else $error("long irq");
endmodule
bind acc_conv_ctrl acc_chk #(.SAR_LATENCY(SAR_LATENCY)) chk_i (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .conv_irq_enable(conv_irq_enable),
  .sar_done(sar_done), .sar_start(sar_start), .sar_power_on(sar_power_on),
  .sar_input_connect(sar_input_connect), .conv_irq(conv_irq));

// [bench/acc_sar_model.sv]
// partner: analog core model, answers each start after a short or a long delay
`timescale 1ns/1ps
module acc_sar_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // core handshake
  input wire logic sar_start,
  input wire logic slow,
  output logic sar_done
);
  int cnt;
  always @(posedge clk or negedge rstn)
    if (!rstn) begin
      cnt <= 0;
      sar_done <= 1'b0;
    end else begin
      cnt <= sar_start ? (slow ? 20 : 6) : cnt - (cnt > 0);
      sar_done <= cnt == 1;
    end
endmodule

// [bench/acc_conv_ctrl_bench.sv]
// bench: apb driver, trigger stimulus and read-back checks
`timescale 1ns/1ps
module acc_conv_ctrl_bench import acc_pkg::*; ();
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, p04 = 0, p13 = 0, slow = 1, e, irq_en = 1;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, lfsr = 32'hA85878EB, prdata;
  acc_pwm_t pwm = '0;
  logic pready, pslverr, sar_done, sar_start, sar_power_on, conv_irq;
  logic [8:0] conn, q[$];
  int failures = 0, compares = 0, nst = 0, nirq = 0, cyc = 0, n, m;
  always #4 clk = ~clk;
  acc_conv_ctrl #(.SAR_LATENCY(8'h02)) dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_in(pwm), .port0_bit4(p04), .port1_bit3(p13), .conv_irq_enable(irq_en),
    .sar_done(sar_done), .sar_start(sar_start), .sar_power_on(sar_power_on),
    .sar_input_connect(conn), .conv_irq(conv_irq));
  acc_sar_model core (.clk(clk), .rstn(rstn), .sar_start(sar_start), .slow(slow), .sar_done(sar_done));
  task automatic chk(input logic [8:0] s, input logic [8:0] x);
    compares++;
    if (s !== x) begin
      failures++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic results();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // reads note their expectation; the monitor below compares at the access edge
  task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [8:0] x);
    if (!w) q.push_back(x);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 0;
    penable <= 0;
  endtask
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // unselected channels and the other pin move the opposite way, so a wrong pick never fires in the cycle the selected one does
  task automatic fire(input int k, input logic [1:0] c, input logic hi);
    logic v;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      v = (i == 0) ^ c[0];
      pwm <= {v ? 3'h1 << k : ~(3'h1 << k), (i == 1 && c == ACC_TRG_CENTRE) ? 3'h1 << k : 3'h0,
        (i == 1 && c == ACC_TRG_END) ? 3'h1 << k : 3'h0};
      p04 <= v ^ hi;
      p13 <= v ^ ~hi;
    end
  endtask
  always @(posedge clk)
    if (psel && penable && pready === 1'b1 && !pwrite) chk({pslverr, prdata[7:0]}, q.pop_front());
  always @(posedge clk) begin
    nst <= nst + sar_start;
    nirq <= nirq + conv_irq;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      results();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1;
    ap(0, ACC_ADDR_CTRL_ZERO, 0, 9'h000);
    ap(0, ACC_ADDR_CTRL_ONE, 0, 9'h000);
    ap(0, ACC_ADDR_STATUS, 0, 9'h001);
    ap(0, 12'h008, 0, 9'h100);
    ap(1, ACC_ADDR_CTRL_ONE, 32'hFF, 0);
    ap(0, ACC_ADDR_CTRL_ONE, 0, 9'h04F);
    for (int ch = 0; ch < 10; ch++) begin
      ap(1, ACC_ADDR_CTRL_ZERO, ch, 0);
      repeat (2) @(posedge clk);
      chk(conn, ch < 9 ? 9'h1 << ch : 9'h0);
    end
    ap(1, ACC_ADDR_CTRL_ZERO, 32'h3, 0);
    ap(1, ACC_ADDR_CTRL_ONE, 32'h0, 0);
    repeat (2) @(posedge clk);
    chk(conn, 9'h0);
    chk(9'(sar_power_on), 9'h0);
    ap(1, ACC_ADDR_CTRL_ONE, 32'h1, 0);
    ap(1, ACC_ADDR_CTRL_ZERO, 32'h40, 0);
    ap(0, ACC_ADDR_CTRL_ZERO, 0, 9'h040);
    ap(1, ACC_ADDR_CTRL_ZERO, 32'h40, 0);
    repeat (40) @(posedge clk);
    ap(0, ACC_ADDR_CTRL_ZERO, 0, 9'h080);
    ap(1, ACC_ADDR_BITOP, 32'hE, 0);
    ap(1, ACC_ADDR_BITOP, 32'h7, 0);
    ap(1, ACC_ADDR_BITOP, 32'h6, 0);
    ap(0, ACC_ADDR_CTRL_ZERO, 0, 9'h000);
    chk(9'(nst), 9'h1);
    chk(9'(nirq), 9'h1);
    for (int t = 0; t < 16; t++) begin
      lfsr = nx(lfsr);
      e = lfsr[1] | lfsr[2];
      slow <= lfsr[3];
      irq_en <= lfsr[4];
      n = nst;
      m = nirq;
      ap(1, ACC_ADDR_CTRL_ZERO, t / 4 << 4, 0);
      ap(1, ACC_ADDR_CTRL_ONE, {24'h0, lfsr[0], 3'h0, t[1:0], e, 1'b1}, 0);
      fire(t / 4, t[1:0], lfsr[0]);
      fire(t / 4, t[1:0], lfsr[0]);
      repeat (40) @(posedge clk);
      chk(9'(nst - n), {8'h0, e && t < 14});
      chk(9'(nirq - m), {8'h0, e && t < 14 && lfsr[4]});
    end
    results();
  end
endmodule
